// File: osc_core.sv
`timescale 1ns/10ps
module osc_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    input wire logic [osc_pkg::NCH-1:0] channel_input_pin,
    input wire logic [osc_pkg::NCH-1:0] over_temp,
    input wire logic [osc_pkg::NDYN-1:0] dyn_temp,
    input wire logic [osc_pkg::NCH-1:0] overload,
    input wire logic ground_lost,
    output logic [osc_pkg::NCH-1:0] channel_drive,
    output logic [osc_pkg::NLED-1:0] load_type_bit,
    output logic [osc_pkg::NCH-1:0] thermal_latched
);
    typedef struct packed {
        logic [osc_pkg::SYNC_W-1:0] sync1;
        logic [osc_pkg::SYNC_W-1:0] sync2;
        logic tgl_seen;
        logic [osc_pkg::NCH-1:0] out;
        logic [osc_pkg::CMB_W-1:0] cmb;
        logic [osc_pkg::NCH-1:0] therm;
        logic [osc_pkg::NCH-1:0] load_flag;
        osc_pkg::osc_tx_e tx_src;
        logic [osc_pkg::FRAME_BITS-1:0] tx_word;
        logic [osc_pkg::NCH-1:0] drive;
    } osc_state_s;

    osc_state_s s;
    osc_state_s next_s;

    logic [osc_pkg::FRAME_BITS-1:0] rx_word;
    logic rx_toggle;
    logic frame_done;
    logic idle;
    logic wr;
    logic bank;
    logic [osc_pkg::ADDR_W-1:0] addr;
    logic ctl_cmd;
    logic gnd_s;
    logic [osc_pkg::NCH-1:0] in_s;
    logic [osc_pkg::NCH-1:0] ot_s;
    logic [osc_pkg::NCH-1:0] ovl_s;
    logic [osc_pkg::NCH-1:0] dyn_s;
    logic [osc_pkg::NCH-1:0] cmd;
    logic [osc_pkg::NCH-1:0] force_off;
    logic [osc_pkg::NCH-1:0] set_flags;
    logic [osc_pkg::NCH-1:0] err;

    ////////////////////////////////////////////////////////////////////////
    osc_link #(
        .BITS(osc_pkg::FRAME_BITS)
    ) u_link (
        .sclk(sclk),
        .srst(srst),
        .cs_n(cs_n),
        .mosi(mosi),
        .tx_word(s.tx_word),
        .miso(miso),
        .rx_word(rx_word),
        .rx_toggle(rx_toggle)
    );

    ////////////////////////////////////////////////////////////////////////
    // synchronised views; only sync2 is ever read
    assign in_s = s.sync2[osc_pkg::SY_IN +: osc_pkg::NCH];
    assign ot_s = s.sync2[osc_pkg::SY_OT +: osc_pkg::NCH];
    assign ovl_s = s.sync2[osc_pkg::SY_OVL +: osc_pkg::NCH];
    assign dyn_s = {1'b0, s.sync2[osc_pkg::SY_DYN +: osc_pkg::NDYN]};
    assign gnd_s = s.sync2[osc_pkg::SY_GND];
    assign idle = s.sync2[osc_pkg::SY_CS];
    // toggle edge: rx_word has been stable for two clk edges by now
    assign frame_done = s.sync2[osc_pkg::SY_TGL] ^ s.tgl_seen;

    // frame decode
    assign wr = rx_word[osc_pkg::BIT_WRITE];
    assign bank = rx_word[osc_pkg::BIT_BANK];
    assign addr = rx_word[osc_pkg::ADDR_LSB +: osc_pkg::ADDR_W];
    assign ctl_cmd = frame_done && wr && bank && (addr == osc_pkg::ADDR_HW)
        && rx_word[osc_pkg::CTL_BIT];

    // flags that set the error bits this cycle
    assign set_flags = ovl_s | dyn_s;
    assign err = s.therm | s.load_flag;

    ////////////////////////////////////////////////////////////////////////
    // per-channel command and forced-off terms
    genvar g;
    generate
        for (g = 0; g < osc_pkg::NCH; g++)
        begin : g_ch
            assign cmd[g] = s.cmb[osc_pkg::COMBINE_BIT]
                ? (in_s[g] & s.out[g])
                : (in_s[g] | s.out[g]);
            if (g < osc_pkg::NDYN)
            begin : g_prot
                // channel 5 rides through ground loss on purpose
                assign force_off[g] = s.therm[g] | ot_s[g] | dyn_s[g] | gnd_s;
            end
            else
            begin : g_noprot
                assign force_off[g] = s.therm[g] | ot_s[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_s = s;
        next_s.sync1 = {cs_n, ground_lost, overload, dyn_temp, over_temp,
            channel_input_pin, rx_toggle};
        next_s.sync2 = s.sync1;
        next_s.tgl_seen = s.sync2[osc_pkg::SY_TGL];

        // thermal latch; a trip in the clear cycle still wins
        next_s.therm = s.therm | ot_s;
        if (ctl_cmd)
        begin
            next_s.therm = ot_s;
        end

        // sticky overload flags, cleared only for the bits just sent
        next_s.load_flag = s.load_flag | set_flags;
        if (frame_done && s.tx_src == osc_pkg::TX_DIAG)
        begin
            next_s.load_flag = (s.load_flag & ~s.tx_word[osc_pkg::NCH-1:0]) | set_flags;
        end

        if (frame_done)
        begin
            next_s.tx_src = osc_pkg::TX_DIAG;
            if (!bank)
            begin
                if (wr)
                    next_s.out = rx_word[osc_pkg::NCH-1:0];
                else
                    next_s.tx_src = osc_pkg::TX_OUT;
            end
            else if (addr == osc_pkg::ADDR_CMB)
            begin
                if (wr)
                    next_s.cmb = rx_word[osc_pkg::CMB_W-1:0];
                else
                    next_s.tx_src = osc_pkg::TX_CMB;
            end
            else if (addr == osc_pkg::ADDR_HW && !wr)
            begin
                next_s.tx_src = osc_pkg::TX_ZERO;
            end
        end

        // answer word changes only between frames, never under a running shift
        if (idle && !frame_done)
        begin
            unique case (s.tx_src)
                osc_pkg::TX_DIAG: next_s.tx_word = {2'h0, err};
                osc_pkg::TX_OUT: next_s.tx_word = {2'h0, s.out};
                osc_pkg::TX_CMB: next_s.tx_word = {4'h0, s.cmb};
                osc_pkg::TX_ZERO: next_s.tx_word = osc_pkg::TX_RST;
            endcase
        end

        next_s.drive = cmd & ~force_off;

        if (srst)
        begin
            next_s = '0;
            next_s.out = osc_pkg::OUT_RST;
            next_s.cmb = osc_pkg::CMB_RST;
            // a channel still hot stays latched across reset
            next_s.therm = ot_s;
            next_s.load_flag = osc_pkg::FLAG_RST;
            next_s.tx_src = osc_pkg::TX_DIAG;
            next_s.tx_word = osc_pkg::TX_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        s <= next_s;
    end

    assign channel_drive = s.drive;
    assign load_type_bit = s.cmb[osc_pkg::NLED-1:0];
    assign thermal_latched = s.therm;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic [osc_pkg::NCH-1:0] rx_low;
    logic [osc_pkg::CMB_W-1:0] rx_cmb;
    assign rx_low = rx_word[osc_pkg::NCH-1:0];
    assign rx_cmb = rx_word[osc_pkg::CMB_W-1:0];

    a_ground_off: assert property (
        gnd_s |=> channel_drive[osc_pkg::NDYN-1:0] == '0)
        else $error("channel on during ground loss");

    a_or_combine: assert property (
        (!s.cmb[osc_pkg::COMBINE_BIT] && force_off == '0)
        |=> channel_drive == $past(in_s | s.out))
        else $error("or combine wrong");

    a_and_combine: assert property (
        (s.cmb[osc_pkg::COMBINE_BIT] && force_off == '0)
        |=> channel_drive == $past(in_s & s.out))
        else $error("and combine wrong");

    a_therm_off: assert property (
        (s.therm != '0) |=> ((channel_drive & $past(s.therm)) == '0))
        else $error("latched channel driven");

    a_therm_sets: assert property (
        (ot_s != '0) |=> ((s.therm & $past(ot_s)) == $past(ot_s)))
        else $error("thermal latch not set");

    a_therm_hold: assert property (
        !ctl_cmd |=> ((s.therm & $past(s.therm)) == $past(s.therm)))
        else $error("thermal latch lost without clear");

    a_clear_all: assert property (
        ctl_cmd |=> s.therm == $past(ot_s))
        else $error("clear command did not clear all");

    a_dyn_off: assert property (
        (dyn_s != '0) |=> ((channel_drive & $past(dyn_s)) == '0))
        else $error("dynamic trip not forcing off");

    a_dyn_flag: assert property (
        (dyn_s != '0) |=> ((s.load_flag & $past(dyn_s)) == $past(dyn_s)))
        else $error("dynamic flag not set");

    a_ch5_no_dyn: assert property (
        s.load_flag[osc_pkg::NCH-1] |-> $past(ovl_s[osc_pkg::NCH-1])
        || $past(s.load_flag[osc_pkg::NCH-1]))
        else $error("channel 5 flag set without overload");

    a_out_write: assert property (
        (frame_done && wr && !bank) |=> s.out == $past(rx_low))
        else $error("output register write lost");

    a_cmb_write: assert property (
        (frame_done && wr && bank && addr == osc_pkg::ADDR_CMB)
        |=> s.cmb == $past(rx_cmb))
        else $error("combine register write lost");

    a_led_out: assert property (
        (frame_done && wr && bank && addr == osc_pkg::ADDR_CMB)
        |=> load_type_bit == $past(rx_cmb[osc_pkg::NLED-1:0]))
        else $error("load type output mismatch");

    a_diag_clear: assert property (
        (frame_done && s.tx_src == osc_pkg::TX_DIAG && set_flags == '0)
        |=> ((s.load_flag & $past(s.tx_word[osc_pkg::NCH-1:0])) == '0))
        else $error("sent flags not cleared");

    a_read_back: assert property (
        (frame_done && !wr && !bank) ##1 (idle && !frame_done)[*2]
        |-> s.tx_word == {2'h0, s.out})
        else $error("output register readback wrong");

    a_reset_vals: assert property (
        disable iff (1'b0) srst |=> (s.out == '0 && s.cmb == '0 && s.load_flag == '0))
        else $error("reset values wrong");

    a_out_hold: assert property (
        !(frame_done && wr && !bank) |=> $stable(s.out))
        else $error("output register changed without write");

    a_cmb_hold: assert property (
        !(frame_done && wr && bank && addr == osc_pkg::ADDR_CMB)
        |=> $stable(s.cmb))
        else $error("combine register changed without write");

    a_cmb_read: assert property (
        (frame_done && !wr && bank && addr == osc_pkg::ADDR_CMB) ##1 (idle && !frame_done)[*2]
        |-> s.tx_word == {4'h0, s.cmb})
        else $error("combine register readback wrong");

    // a command register read answers zero, never stale data
    a_hw_read_zero: assert property (
        (frame_done && !wr && bank && addr == osc_pkg::ADDR_HW) ##1 (idle && !frame_done)[*2]
        |-> s.tx_word == '0)
        else $error("command register read not zero");

    // a change here would corrupt an answer already being shifted out
    a_tx_frozen: assert property (
        (!$past(idle) && !$past(srst)) |-> $stable(s.tx_word))
        else $error("answer word changed inside a frame");

    a_flag_sticky: assert property (
        !(frame_done && s.tx_src == osc_pkg::TX_DIAG)
        |=> ((s.load_flag & $past(s.load_flag)) == $past(s.load_flag)))
        else $error("error flag lost without diagnosis");

    a_ovl_flag: assert property (
        (ovl_s != '0) |=> ((s.load_flag & $past(ovl_s)) == $past(ovl_s)))
        else $error("overload flag not set");

    a_ch5_gnd_free: assert property (
        (gnd_s && !s.therm[osc_pkg::NCH-1] && !ot_s[osc_pkg::NCH-1])
        |=> channel_drive[osc_pkg::NCH-1] == $past(cmd[osc_pkg::NCH-1]))
        else $error("channel 5 dropped during ground loss");

    a_diag_word: assert property (
        (idle && !frame_done && s.tx_src == osc_pkg::TX_DIAG)
        |=> s.tx_word == {2'h0, $past(err)})
        else $error("diagnosis word wrong");

    a_therm_reset: assert property (
        disable iff (1'b0) srst |=> s.therm == $past(ot_s))
        else $error("hot channel unlatched by reset");

    a_no_cmd_off: assert property (
        (cmd == '0) |=> channel_drive == '0)
        else $error("channel driven without command");

    c_out_write: cover property (frame_done && wr && !bank);
    c_clear_cmd: cover property (ctl_cmd && s.therm != '0);
    c_dyn_trip: cover property (dyn_s != '0 ##1 s.load_flag != '0);
    c_gnd_loss: cover property (gnd_s && cmd != '0);
    c_and_mode: cover property (s.cmb[osc_pkg::COMBINE_BIT] && channel_drive != '0);
endmodule // osc_core

// File: osc_host_model.sv
`timescale 1ns/10ps
module osc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one 8-bit frame, msb first; link clock runs only inside the frame
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        #160; // setup of 3+ clk cycles before the first edge
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx[i];
            #32;
            rx[i] = miso; // sampled before the edge that shifts it on
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #32;
        cs_n = 1'b1;
        mosi = ~mosi; // idle line must not look like held data
        #400; // idle gap of 8 clk cycles
    endtask
endmodule // osc_host_model

// File: osc_link.sv
`timescale 1ns/10ps
module osc_link #(
    parameter int BITS = osc_pkg::FRAME_BITS
) (
    input wire logic sclk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [BITS-1:0] tx_word,
    output logic miso,
    output logic [BITS-1:0] rx_word,
    output logic rx_toggle
);
    typedef struct packed {
        logic [osc_pkg::CNT_W-1:0] cnt;
        logic [BITS-2:0] shreg;
        logic [BITS-1:0] rx;
        logic tgl;
    } osc_link_s;

    osc_link_s s;
    osc_link_s next_s;

    ////////////////////////////////////////////////////////////////////////
    // shift on rising sclk; the frame's own select ends the count, since
    // sclk may stop dead once the frame is over
    always_comb
    begin
        next_s = s;
        next_s.shreg = {s.shreg[BITS-3:0], mosi};
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == osc_pkg::CNT_W'(BITS-1))
        begin
            next_s.rx = {s.shreg, mosi};
            next_s.tgl = ~s.tgl;
        end
    end

    always_ff @(posedge sclk or posedge cs_n or posedge srst)
    begin
        if (srst)
            s <= '0;
        else if (cs_n)
            s.cnt <= '0;
        else
            s <= next_s;
    end

    // tx_word is frozen by the core while the frame runs
    assign miso = tx_word[osc_pkg::CNT_W'(BITS-1) - s.cnt];
    assign rx_word = s.rx;
    assign rx_toggle = s.tgl;
endmodule // osc_link

// File: osc_pkg.sv
package osc_pkg;
    // channel counts
    localparam int NCH = 6;
    localparam int NDYN = 5;
    localparam int NLED = 3;
    localparam int FRAME_BITS = 8;
    localparam int CNT_W = $clog2(FRAME_BITS);

    // frame field positions, most significant bit shifted first
    localparam int BIT_WRITE = 7;
    localparam int BIT_BANK = 6;
    localparam int ADDR_LSB = 4;
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_CMB = 2'h1;
    localparam logic [1:0] ADDR_HW = 2'h2;

    // combine_load_type_reg layout
    localparam int CMB_W = 4;
    localparam int COMBINE_BIT = 3;
    localparam int CTL_BIT = 0;

    // reset values
    localparam logic [5:0] OUT_RST = 6'h00;
    localparam logic [3:0] CMB_RST = 4'h0;
    localparam logic [7:0] TX_RST = 8'h00;
    localparam logic [5:0] FLAG_RST = 6'h00;

    // synchroniser vector layout
    localparam int SY_TGL = 0;
    localparam int SY_IN = 1;
    localparam int SY_OT = 7;
    localparam int SY_DYN = 13;
    localparam int SY_OVL = 18;
    localparam int SY_GND = 24;
    localparam int SY_CS = 25;
    localparam int SYNC_W = 26;

    typedef enum logic [1:0] {TX_DIAG, TX_OUT, TX_CMB, TX_ZERO} osc_tx_e;
endpackage

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk, srst, sclk, cs_n, mosi, miso, ground_lost;
    logic [5:0] pin, ot, ovl, drive, lat;
    logic [4:0] dyn;
    logic [2:0] led;
    logic [7:0] rx;
    int err_count, n_checks, cyc, seed, out_m, cmb_m, lat_m;
    int exp_q[$];

    osc_core dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .channel_input_pin(pin), .over_temp(ot), .dyn_temp(dyn),
        .overload(ovl), .ground_lost(ground_lost), .channel_drive(drive),
        .load_type_bit(led), .thermal_latched(lat));
    osc_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_count++; // hang: count it and close
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic xf(input int t);
        host.xfer(t[7:0], rx);
        wt(4); // register lands 3 edges after the frame, drive one later
    endtask
    // reference drive, all from the model state
    function automatic logic [7:0] exp_drive();
        int d;
        d = cmb_m[3] ? (out_m & pin) : (out_m | pin);
        d = d & ~lat_m & ~{1'b0, dyn};
        if (ground_lost)
            d = d & 32'h20; // last channel keeps its command
        return d[7:0];
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'hedbf2956;
        // start low so the link's asynchronous clear sees a real rising edge
        {srst, pin, ot, ovl, dyn, ground_lost} = {1'b0, 24'h0};
        #1;
        srst = 1'b1;
        {out_m, cmb_m, lat_m} = '0;
        wt(3);
        srst = 1'b0;
        wt(5);
        chk({2'h0, drive}, 8'h00);
        chk({5'h0, led}, 8'h00);
        $display("test reset done");
        for (int k = 0; k < 8; k++)
        begin
            out_m = $random(seed) & 32'h3f;
            cmb_m = ($random(seed) & 32'h7) | (k[0] << 3);
            pin = 6'($random(seed));
            xf(32'h80 | out_m);
            xf(32'hd0 | cmb_m);
            chk(drive, exp_drive());
            chk({5'h0, led}, cmb_m[2:0]);
            exp_q.push_back(out_m);
            exp_q.push_back(cmb_m);
            xf(32'h00);
            xf(32'h50);
            chk(rx, 8'(exp_q.pop_front()));
            xf(32'he0);
            chk(rx, 8'(exp_q.pop_front()));
        end
        xf(32'h60);
        xf(32'he0);
        chk(rx, 8'h00);
        $display("test registers and combine done");
        pin = 6'h00;
        out_m = 63;
        cmb_m = 0;
        xf(32'hbf);
        xf(32'hd0);
        ot = 6'h24;
        lat_m = 6'h24;
        wt(5);
        chk({2'h0, lat}, 8'h24);
        chk(drive, exp_drive());
        ot = 6'h04; // channel 2 still hot
        wt(5);
        chk({2'h0, lat}, 8'h24);
        xf(32'he1);
        lat_m = 6'h04;
        chk({2'h0, lat}, 8'h04);
        chk(drive, exp_drive());
        ot = 6'h00;
        wt(5);
        xf(32'he1);
        lat_m = 0;
        chk({2'h0, lat}, 8'h00);
        chk(drive, exp_drive());
        $display("test thermal latch done");
        dyn = 5'h02;
        wt(5);
        chk(drive, exp_drive());
        xf(32'he0);
        chk(rx, 8'h02);
        xf(32'he0);
        chk(rx, 8'h02);
        dyn = 5'h00;
        wt(5);
        xf(32'he0);
        chk(rx, 8'h02);
        xf(32'he0);
        chk(rx, 8'h00);
        chk(drive, exp_drive());
        $display("test dynamic sensor done");
        ovl = 6'h28;
        wt(5);
        ovl = 6'h00; // short pulse must be held by the flag
        wt(5);
        xf(32'he0);
        chk(rx, 8'h28);
        xf(32'he0);
        chk(rx, 8'h00);
        $display("test overload flag done");
        ground_lost = 1'b1;
        wt(5);
        chk(drive, exp_drive());
        ground_lost = 1'b0;
        wt(5);
        chk(drive, exp_drive());
        $display("test ground loss done");
        test_done();
    end
endmodule // tb_top
